//--- rtl/pcs_cmd_status.sv
// Implementation choice: register access over AHB-Lite.
module pcs_cmd_status #(
  parameter logic [1:0] SELECT_TIMING = pcs_pkg::TIM_MEDIUM
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // Master engine requests and bus events
  input  wire logic        mst_req_i,
  input  wire logic        mst_mwi_req_i,
  input  wire logic        mst_special_i,
  input  wire logic        mst_master_abort_i,
  input  wire logic        mst_target_abort_i,
  // Target side decode and events
  input  wire logic        tgt_mem_hit_i,
  input  wire logic        tgt_io_hit_i,
  input  wire logic        tgt_special_cycle_i,
  input  wire logic        tgt_abort_sent_i,
  input  wire logic        parity_error_i,
  input  wire logic        serr_drive_i,
  // Gated controls
  output logic             mst_go_o,
  output logic             mst_use_mwi_o,
  output logic             tgt_mem_claim_o,
  output logic             tgt_io_claim_o,
  output logic             special_cycle_accept_o,
  output logic             write_invalidate_enable_o,
  output logic             master_enable_o,
  // Interrupt
  output logic             irq_o
);

  // ****************************************
  // Elaboration check
  // ****************************************
  // The reserved timing code would advertise an illegal select timing
  if (SELECT_TIMING == pcs_pkg::TIM_RESERVED) begin : g_bad_timing
    $error("SELECT_TIMING must not use the reserved code");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                         hreadyout;
    logic                         hresp;
    logic [31:0]                  hrdata;
    logic                         wr_pend;
    logic [7:0]                   wr_idx;
    logic [pcs_pkg::CMD_W-1:0]    cmd;
    logic                         perr;
    logic                         serr;
    logic                         ma_rcvd;
    logic                         ta_rcvd;
    logic                         ta_sent;
    logic [pcs_pkg::EV_W-1:0]     irq_sts;
    logic [pcs_pkg::EV_W-1:0]     irq_mask;
    logic                         irq;
    logic                         mst_go;
    logic                         mst_use_mwi;
    logic                         mem_claim;
    logic                         io_claim;
    logic                         sc_accept;
  } pcs_state_t;

  localparam pcs_state_t STATE_RESET = '{
    hreadyout:   1'b1,
    hresp:       pcs_pkg::HRESP_OKAY,
    hrdata:      32'h0000_0000,
    wr_pend:     1'b0,
    wr_idx:      8'h00,
    cmd:         pcs_pkg::CMD_RESET,
    perr:        1'b0,
    serr:        1'b0,
    ma_rcvd:     1'b0,
    ta_rcvd:     1'b0,
    ta_sent:     1'b0,
    irq_sts:     pcs_pkg::EV_RESET,
    irq_mask:    pcs_pkg::EV_RESET,
    irq:         1'b0,
    mst_go:      1'b0,
    mst_use_mwi: 1'b0,
    mem_claim:   1'b0,
    io_claim:    1'b0,
    sc_accept:   1'b0
  };

  pcs_state_t state_q;
  pcs_state_t state_d;

  // ****************************************
  // Decoding
  // ****************************************
  function automatic logic [7:0] addr_to_idx(input logic [31:0] addr);
    logic [pcs_pkg::ADDR_W-1:0] low;
    low = addr[pcs_pkg::ADDR_W-1:0];
    addr_to_idx = low[pcs_pkg::IDX_SHIFT +: 8];
  endfunction

  function automatic logic [15:0] status_word(input pcs_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[pcs_pkg::STS_PERR]    = s.perr;
    w[pcs_pkg::STS_SERR]    = s.serr;
    w[pcs_pkg::STS_MA_RCVD] = s.ma_rcvd;
    w[pcs_pkg::STS_TA_RCVD] = s.ta_rcvd;
    w[pcs_pkg::STS_TA_SENT] = s.ta_sent;
    w[pcs_pkg::STS_TIM_LO +: 2] = SELECT_TIMING;
    w[pcs_pkg::STS_CAP_BIT] = 1'b1;
    status_word = w;
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] idx, input pcs_state_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (idx)
      pcs_pkg::CMD_IDX:      r[pcs_pkg::CMD_W-1:0] = s.cmd;
      pcs_pkg::STS_IDX:      r[15:0] = status_word(s);
      pcs_pkg::IRQ_STS_IDX:  r[pcs_pkg::EV_W-1:0] = s.irq_sts;
      pcs_pkg::IRQ_MASK_IDX: r[pcs_pkg::EV_W-1:0] = s.irq_mask;
      default:               r = 32'h0000_0000;
    endcase
    read_mux = r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic                     addr_phase;
  logic [pcs_pkg::EV_W-1:0] events;
  logic [pcs_pkg::EV_W-1:0] w1c;
  logic [pcs_pkg::CMD_W-1:0] cmd_n;

  always_comb begin
    state_d    = state_q;
    addr_phase = hsel_i && hready_i && htrans_i[1];
    w1c        = '0;
    cmd_n      = state_q.cmd;

    events = '0;
    events[pcs_pkg::EV_PERR]    = parity_error_i;
    events[pcs_pkg::EV_SERR]    = serr_drive_i;
    events[pcs_pkg::EV_MA_RCVD] = mst_master_abort_i && !mst_special_i;
    events[pcs_pkg::EV_TA_RCVD] = mst_target_abort_i;
    events[pcs_pkg::EV_TA_SENT] = tgt_abort_sent_i;

    // Data phase of a write: only command and interrupt registers take data
    if (state_q.wr_pend) begin
      unique case (state_q.wr_idx)
        pcs_pkg::CMD_IDX:      cmd_n = hwdata_i[pcs_pkg::CMD_W-1:0];
        pcs_pkg::IRQ_STS_IDX:  w1c = hwdata_i[pcs_pkg::EV_W-1:0];
        pcs_pkg::IRQ_MASK_IDX: state_d.irq_mask = hwdata_i[pcs_pkg::EV_W-1:0];
        default:               w1c = '0;
      endcase
    end
    state_d.cmd = cmd_n;

    // Sticky status flags, cleared only by reset
    state_d.perr    = state_q.perr    | events[pcs_pkg::EV_PERR];
    state_d.serr    = state_q.serr    | events[pcs_pkg::EV_SERR];
    state_d.ma_rcvd = state_q.ma_rcvd | events[pcs_pkg::EV_MA_RCVD];
    state_d.ta_rcvd = state_q.ta_rcvd | events[pcs_pkg::EV_TA_RCVD];
    state_d.ta_sent = state_q.ta_sent | events[pcs_pkg::EV_TA_SENT];

    // A new event wins over a clear in the same cycle
    state_d.irq_sts = (state_q.irq_sts & ~w1c) | events;
    state_d.irq     = |(state_d.irq_sts & state_d.irq_mask);

    // Address phase: capture writes, fetch read data for the next cycle
    state_d.wr_pend   = addr_phase && hwrite_i && (hsize_i == pcs_pkg::HSIZE_WORD);
    state_d.wr_idx    = addr_to_idx(haddr_i);
    state_d.hreadyout = 1'b1;
    state_d.hresp     = pcs_pkg::HRESP_OKAY;
    if (addr_phase && !hwrite_i) begin
      state_d.hrdata = read_mux(addr_to_idx(haddr_i), state_q);
    end

    // Controls are gated by the command bits as they stand after any write
    state_d.mst_go      = mst_req_i && cmd_n[pcs_pkg::CMD_MST_BIT];
    state_d.mst_use_mwi = mst_req_i && cmd_n[pcs_pkg::CMD_MST_BIT] && mst_mwi_req_i
                          && cmd_n[pcs_pkg::CMD_WIE_BIT];
    state_d.mem_claim   = tgt_mem_hit_i && cmd_n[pcs_pkg::CMD_MEM_BIT];
    state_d.io_claim    = tgt_io_hit_i && cmd_n[pcs_pkg::CMD_IO_BIT];
    state_d.sc_accept   = tgt_special_cycle_i && cmd_n[pcs_pkg::CMD_SC_BIT];
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hreadyout_o               = state_q.hreadyout;
  assign hresp_o                   = state_q.hresp;
  assign hrdata_o                  = state_q.hrdata;
  assign mst_go_o                  = state_q.mst_go;
  assign mst_use_mwi_o             = state_q.mst_use_mwi;
  assign tgt_mem_claim_o           = state_q.mem_claim;
  assign tgt_io_claim_o            = state_q.io_claim;
  assign special_cycle_accept_o    = state_q.sc_accept;
  assign write_invalidate_enable_o = state_q.cmd[pcs_pkg::CMD_WIE_BIT];
  assign master_enable_o           = state_q.cmd[pcs_pkg::CMD_MST_BIT];
  assign irq_o                     = state_q.irq;

endmodule

//--- rtl/pcs_pkg.sv
package pcs_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam logic [7:0]  CMD_IDX       = 8'h04;
  localparam logic [7:0]  STS_IDX       = 8'h06;
  localparam logic [7:0]  IRQ_STS_IDX   = 8'h08;
  localparam logic [7:0]  IRQ_MASK_IDX  = 8'h09;
  localparam int          IDX_SHIFT     = 2;
  localparam int          ADDR_W        = 10;

  // ****************************************
  // Command register fields
  // ****************************************
  localparam int          CMD_IO_BIT    = 0;
  localparam int          CMD_MEM_BIT   = 1;
  localparam int          CMD_MST_BIT   = 2;
  localparam int          CMD_SC_BIT    = 3;
  localparam int          CMD_WIE_BIT   = 4;
  localparam int          CMD_W         = 5;
  localparam logic [4:0]  CMD_RESET     = 5'h00;

  // ****************************************
  // Status register fields
  // ****************************************
  localparam int          STS_CAP_BIT   = 4;
  localparam int          STS_TIM_LO    = 9;
  localparam int          STS_TA_SENT   = 11;
  localparam int          STS_TA_RCVD   = 12;
  localparam int          STS_MA_RCVD   = 13;
  localparam int          STS_SERR      = 14;
  localparam int          STS_PERR      = 15;
  localparam logic [1:0]  TIM_FAST      = 2'h0;
  localparam logic [1:0]  TIM_MEDIUM    = 2'h1;
  localparam logic [1:0]  TIM_SLOW      = 2'h2;
  localparam logic [1:0]  TIM_RESERVED  = 2'h3;

  // ****************************************
  // Event bit order in the interrupt registers
  // ****************************************
  localparam int          EV_PERR       = 0;
  localparam int          EV_SERR       = 1;
  localparam int          EV_MA_RCVD    = 2;
  localparam int          EV_TA_RCVD    = 3;
  localparam int          EV_TA_SENT    = 4;
  localparam int          EV_W          = 5;
  localparam logic [4:0]  EV_RESET      = 5'h00;

  // ****************************************
  // AHB-Lite encodings
  // ****************************************
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic        HRESP_OKAY    = 1'b0;

endpackage

//--- dv/pcs_pci_far.sv
module pcs_pci_far (
  // Clock
  input  wire logic       ref_clk_i,
  // Bus event pulses, bit order as pcs_pkg event bits
  output logic      [4:0] ev_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial ev_o = 5'h00;

  // Events are single-cycle pulses, so a stuck line cannot fake a later event
  task automatic strike(input int k);
    ev_o <= 5'h01 << k;
    @(posedge ref_clk_i);
    ev_o <= 5'h00;
  endtask
endmodule

//--- dv/pcs_cmd_status_properties.sv
module pcs_cmd_status_properties (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // Register bus
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic        hready_i,
  input  wire logic        hreadyout_o,
  input  wire logic        hresp_o,
  input  wire logic [31:0] hrdata_o,
  // Requests and gated controls
  input  wire logic        mst_req_i,
  input  wire logic        mst_mwi_req_i,
  input  wire logic        tgt_mem_hit_i,
  input  wire logic        tgt_io_hit_i,
  input  wire logic        tgt_special_cycle_i,
  input  wire logic        mst_go_o,
  input  wire logic        mst_use_mwi_o,
  input  wire logic        tgt_mem_claim_o,
  input  wire logic        tgt_io_claim_o,
  input  wire logic        special_cycle_accept_o,
  input  wire logic        write_invalidate_enable_o,
  input  wire logic        master_enable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  wire logic rd_take = htrans_i[1] && hready_i && !hwrite_i;

  ready_okay_a: assert property (hreadyout_o && hresp_o == pcs_pkg::HRESP_OKAY)
    else $error("bus not ready or not okay");
  status_read_a: assert property (rd_take && haddr_i == 32'h18 |=>
    hrdata_o[31:16] == 16'h0000 && hrdata_o[10:0] == 11'h210) else $error("status pattern wrong");
  command_read_a: assert property (rd_take && haddr_i == 32'h10 |=> hrdata_o[31:5] == 27'h0 &&
    hrdata_o[4] == write_invalidate_enable_o && hrdata_o[2] == master_enable_o) else $error("command read wrong");
  master_gate_a: assert property (mst_go_o |-> $past(mst_req_i) && master_enable_o)
    else $error("master access without enable");
  mwi_gate_a: assert property (mst_use_mwi_o |-> mst_go_o && $past(mst_mwi_req_i) && write_invalidate_enable_o)
    else $error("invalidate write without enable");
  mem_claim_a: assert property (tgt_mem_claim_o |-> $past(tgt_mem_hit_i))
    else $error("memory claim without hit");
  io_claim_a: assert property (tgt_io_claim_o |-> $past(tgt_io_hit_i))
    else $error("io claim without hit");
  special_claim_a: assert property ($rose(special_cycle_accept_o) |-> $past(tgt_special_cycle_i))
    else $error("special cycle accepted unseen");
endmodule

//--- dv/pcs_cmd_status_bench.sv
module pcs_cmd_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_i, nrst_i, hwrite, hready, irq, req, mwi, spec, memh, ioh, sch;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, sts;
  logic [4:0]  ev;
  logic [6:0]  gate;
  int          err_count, checks_done;

  pcs_pci_far p (.ref_clk_i(ref_clk_i), .ev_o(ev));
  pcs_cmd_status dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(pcs_pkg::HSIZE_WORD), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(), .hrdata_o(hrdata), .mst_req_i(req), .mst_mwi_req_i(mwi), .mst_special_i(spec),
    .mst_master_abort_i(ev[2]), .mst_target_abort_i(ev[3]), .tgt_mem_hit_i(memh), .tgt_io_hit_i(ioh),
    .tgt_special_cycle_i(sch), .tgt_abort_sent_i(ev[4]), .parity_error_i(ev[0]), .serr_drive_i(ev[1]),
    .mst_go_o(gate[0]), .mst_use_mwi_o(gate[1]), .tgt_mem_claim_o(gate[2]), .tgt_io_claim_o(gate[3]),
    .special_cycle_accept_o(gate[4]), .write_invalidate_enable_o(gate[5]), .master_enable_o(gate[6]), .irq_o(irq));

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Master waits on hready rather than assuming the zero-wait answer
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    haddr  <= a;
    hwrite <= w;
    htrans <= pcs_pkg::HTRANS_NONSEQ;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_exp(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic look(input logic [7:0] exp);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk({24'h0, irq, gate}, {24'h0, exp});
    @(posedge ref_clk_i);
  endtask

  task automatic reset_and_lock();
    rd_exp(32'h10, 32'h0);
    rd_exp(32'h18, 32'h210);
    rd_exp(32'h30, 32'h0);
    bus(1'b1, 32'h18, 32'hffff);
    rd_exp(32'h18, 32'h210);
  endtask

  task automatic gating();
    {req, mwi, memh, ioh, sch} <= 5'h1f;
    look(8'h00);
    bus(1'b1, 32'h10, 32'h1f);
    look(8'h7f);
    bus(1'b1, 32'h10, 32'h04);
    look(8'h41);
    {req, mwi, memh, ioh, sch} <= 5'h00;
    bus(1'b1, 32'h10, 32'h0);
    look(8'h00);
  endtask

  task automatic events();
    spec <= 1'b1;
    p.strike(2);
    spec <= 1'b0;
    rd_exp(32'h18, 32'h210);
    p.strike(0);
    look(8'h00);
    bus(1'b1, 32'h24, 32'h1f);
    look(8'h80);
    sts = 32'h8210;
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 32'h20, 32'h1f);
      look(8'h00);
      p.strike(k);
      look(8'h80);
      sts[15-k] = 1'b1;
      rd_exp(32'h18, sts);
      rd_exp(32'h20, 32'h1 << k);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100us;
    err_count++;
    test_done();
  end

  initial begin
    nrst_i = 1'b0;
    {hwrite, req, mwi, spec, memh, ioh, sch} = 7'h00;
    htrans = 2'h0;
    haddr  = 32'h0;
    hwdata = 32'h0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    reset_and_lock();
    gating();
    events();
    test_done();
  end
endmodule

bind pcs_cmd_status pcs_cmd_status_properties chk (.ref_clk_i, .nrst_i, .haddr_i, .htrans_i, .hwrite_i,
  .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .mst_req_i, .mst_mwi_req_i, .tgt_mem_hit_i, .tgt_io_hit_i,
  .tgt_special_cycle_i, .mst_go_o, .mst_use_mwi_o, .tgt_mem_claim_o, .tgt_io_claim_o, .special_cycle_accept_o,
  .write_invalidate_enable_o, .master_enable_o);
